// >>> verilog/sleep_gpo_addr_config_regs.sv
// sleep-source, output-mode and bus target address configuration registers
`timescale 1ns/1ps
`include "sleep_gpo_params.svh"

// What this block does
// RULE1: each sleep-source bit picks control input three (0) or six (1).
// RULE2: sample chosen control input; raise rail sleep request while active.
// RULE3: bits 7..4 pick power-good (0) or software value (1) per output.
// RULE4: bits 2..0 pick push-pull (0) or open drain (1), outputs three..one.
// RULE5: address select 0 answers only at fixed target address 0x5E.
// RULE6: address select 1 answers at programmed 7-bit address instead.
// RULE7: software must not program address 0000000 or 0001000.
// RULE8: software must not program address 0111000, used by 0x38 registers.
// RULE9: software must not program addresses 1111000 through 1111111.
// RULE10: sleep source at 29h, output mode at 2Ah, all bits read/write.
// RULE11: all fields load from the one-time-programmable image at power-up.
module sleep_gpo_addr_config_regs
	import sleep_gpo_pkg::*;
#(
	parameter int RAILS   = 8,
	parameter int OUTPUTS = 4
)
(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               nrst_i,
	// default image from one-time-programmable memory
	input  wire logic               otp_valid_i,
	input  wire logic [7:0]         otp_sleep_source_i,
	input  wire logic [7:0]         otp_out_config_i,
	input  wire logic [7:0]         otp_target_addr_i,
	// register port from the serial bus engine
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	input  wire logic [7:0]         reg_addr_i,
	input  wire logic [7:0]         reg_wdata_i,
	output logic      [7:0]         reg_rdata_o,
	output logic                    reg_ack_o,
	// address the bus engine must answer at
	output logic      [6:0]         target_address_o,
	// control inputs used as sleep sources
	input  wire logic               control_input_three_i,
	input  wire logic               control_input_six_i,
	// per-rail sleep requests
	output logic      [RAILS-1:0]   sleep_request_o,
	// general-purpose outputs
	input  wire logic [OUTPUTS-1:0] power_good_i,
	input  wire logic [OUTPUTS-1:0] sw_out_value_i,
	output logic      [OUTPUTS-1:0] out_pin_o,
	output logic      [OUTPUTS-1:0] out_pin_oe_o,
	// configuration loaded and live
	output logic                    config_ready_o
);
	load_state_t        load_reg;
	logic [7:0]         sleep_source_select_reg;
	logic [7:0]         output_pin_config_reg;
	logic [7:0]         bus_target_address_config_reg;
	logic [7:0]         rdata_next;
	logic               hit;
	logic               wr_live;
	logic               rd_live;
	logic [OUTPUTS-1:0] use_register;
	logic [OUTPUTS-1:0] drive_type;

	// image load sequence after reset release
	// a missing image keeps the slice idle: no writes, no sleep requests
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			load_reg <= LOAD_WAIT;
		else
		begin
			case (load_reg)
				LOAD_WAIT: if (otp_valid_i) load_reg <= LOAD_TAKE;
				LOAD_TAKE: load_reg <= LOAD_DONE;
				LOAD_DONE: load_reg <= LOAD_DONE;
				default:   load_reg <= LOAD_WAIT;
			endcase
		end
	end

	// writes and acks count only once the image is in; earlier writes are dropped, earlier reads still return read data
	assign wr_live = reg_wr_i && (load_reg == LOAD_DONE);
	assign rd_live = reg_rd_i && (load_reg == LOAD_DONE);

	// sleep-source select: image first, then bus writes
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			sleep_source_select_reg <= `REG_CLEAR;
		else if (load_reg == LOAD_TAKE)
			sleep_source_select_reg <= otp_sleep_source_i; // [RULE11]
		else if (wr_live && reg_addr_i == `SLEEP_SRC_OFFSET)
			sleep_source_select_reg <= reg_wdata_i; // [RULE10]
	end

	// output source and drive type; bit 3 is stored but unused
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			output_pin_config_reg <= `REG_CLEAR;
		else if (load_reg == LOAD_TAKE)
			output_pin_config_reg <= otp_out_config_i; // [RULE11]
		else if (wr_live && reg_addr_i == `OUT_CFG_OFFSET)
			output_pin_config_reg <= reg_wdata_i; // [RULE10]
	end

	// target address setting; the bus engine picks it up a cycle later
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			bus_target_address_config_reg <= `REG_CLEAR;
		else if (load_reg == LOAD_TAKE)
			bus_target_address_config_reg <= otp_target_addr_i; // [RULE11]
		else if (wr_live && reg_addr_i == `TGT_ADDR_OFFSET)
			bus_target_address_config_reg <= reg_wdata_i;
	end

	// read decode; unmapped offsets read zero
	always_comb
	begin
		rdata_next = `REG_CLEAR;
		hit        = 1'b1;
		case (reg_addr_i)
			`SLEEP_SRC_OFFSET:
				rdata_next = sleep_source_select_reg; // [RULE10]
			`OUT_CFG_OFFSET:
				rdata_next = output_pin_config_reg; // [RULE10]
			`TGT_ADDR_OFFSET:
				rdata_next = bus_target_address_config_reg;
			default:
				hit = 1'b0;
		endcase
	end

	// read data stands for one cycle and is zero otherwise
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			reg_rdata_o <= `REG_CLEAR;
		else if (reg_rd_i && hit)
			reg_rdata_o <= rdata_next; // [RULE10]
		else
			reg_rdata_o <= `REG_CLEAR;
	end

	// every taken request is answered exactly one cycle later
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			reg_ack_o <= 1'b0;
		else
			reg_ack_o <= wr_live || rd_live; // [RULE10]
	end

	// answering address; reserved codes are software's to avoid, the
	// hardware does not filter them
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			target_address_o <= `DEFAULT_TARGET;
		else if (bus_target_address_config_reg[`ADDR_SEL_BIT])
			target_address_o <=
				bus_target_address_config_reg[6:0]; // [RULE6]
		else
			target_address_o <= `DEFAULT_TARGET; // [RULE5]
	end

	// ready rises one cycle after the load finishes
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			config_ready_o <= 1'b0;
		else
			config_ready_o <= load_reg == LOAD_DONE;
	end

	// per-rail sleep source mux, held off until image loaded
	generate
		for (genvar r = 0; r < RAILS; r++)
		begin : g_rail
			always_ff @(posedge clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
					sleep_request_o[r] <= 1'b0;
				else
					sleep_request_o[r] <= (load_reg == LOAD_DONE) &&
						(sleep_source_select_reg[r] ? // [RULE1]
						control_input_six_i :
						control_input_three_i); // [RULE2]
			end
		end
	endgenerate

	// per-output source and drive selection
	generate
		for (genvar g = 0; g < OUTPUTS; g++)
		begin : g_out
			assign use_register[g] =
				output_pin_config_reg[`OUT_SRC_LSB + g]; // [RULE3]
			// outputs without a drive-type bit stay push-pull
			if (g < `OUT_DRIVE_BITS)
			begin : g_mode
				assign drive_type[g] =
					output_pin_config_reg[`OUT_DRIVE_LSB + g]; // [RULE4]
			end
			else
			begin : g_fixed
				assign drive_type[g] = 1'b0; // [RULE4]
			end
			out_pin_driver u_drv
			(
				.clk_i          (clk_i),
				.nrst_i         (nrst_i),
				.use_register_i (use_register[g]), // [RULE3]
				.open_drain_i   (drive_type[g]), // [RULE4]
				.power_good_i   (power_good_i[g]),
				.sw_value_i     (sw_out_value_i[g]),
				.pin_o          (out_pin_o[g]),
				.pin_oe_o       (out_pin_oe_o[g])
			);
		end
	endgenerate
endmodule : sleep_gpo_addr_config_regs

// >>> verilog/sleep_gpo_params.svh
// register offsets, field positions and fixed values of the config slice
`ifndef SLEEP_GPO_PARAMS_SVH
`define SLEEP_GPO_PARAMS_SVH
`define SLEEP_SRC_OFFSET   8'h29
`define OUT_CFG_OFFSET     8'h2A
`define TGT_ADDR_OFFSET    8'h2B
`define OUT_SRC_LSB        4
`define OUT_DRIVE_LSB      0
`define OUT_DRIVE_BITS     3
`define ADDR_SEL_BIT       7
`define DEFAULT_TARGET     7'h5E
`define REG_CLEAR          8'h00
`endif

// >>> verilog/sleep_gpo_pkg.sv
// types shared by the configuration slice
package sleep_gpo_pkg;
	typedef enum logic [1:0] {
		LOAD_WAIT,
		LOAD_TAKE,
		LOAD_DONE
	} load_state_t;
endpackage : sleep_gpo_pkg

// >>> verilog/out_pin_driver.sv
// one general-purpose output: source mux and push-pull/open-drain drive
`timescale 1ns/1ps
module out_pin_driver
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// configuration
	input  wire logic use_register_i,
	input  wire logic open_drain_i,
	// sources
	input  wire logic power_good_i,
	input  wire logic sw_value_i,
	// pin
	output logic      pin_o,
	output logic      pin_oe_o
);
	logic level;

	assign level = use_register_i ? sw_value_i : power_good_i;

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_o    <= 1'b0;
			pin_oe_o <= 1'b0;
		end
		else
		begin
			// open drain only pulls low, floats for a high level
			pin_o    <= open_drain_i ? 1'b0 : level;
			pin_oe_o <= open_drain_i ? ~level : 1'b1;
		end
	end
endmodule : out_pin_driver

// >>> dv/cfg_slice_chk.sv
// port-level assertions for the configuration slice
`timescale 1ns/1ps
module cfg_slice_chk
#(
	parameter int RAILS   = 8,
	parameter int OUTPUTS = 4
)
(
	input wire logic               clk_i,
	input wire logic               nrst_i,
	input wire logic               reg_wr_i,
	input wire logic               reg_rd_i,
	input wire logic [7:0]         reg_rdata_o,
	input wire logic               reg_ack_o,
	input wire logic               control_input_three_i,
	input wire logic               control_input_six_i,
	input wire logic [RAILS-1:0]   sleep_request_o,
	input wire logic [OUTPUTS-1:0] out_pin_o,
	input wire logic [OUTPUTS-1:0] out_pin_oe_o,
	input wire logic               config_ready_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence taken_s;
		config_ready_o && (reg_wr_i || reg_rd_i);
	endsequence
	a_ack_after_req: assert property (taken_s |=> reg_ack_o)
		else $error("ack missing");
	a_no_stray_ack: assert property (
		!(reg_wr_i || reg_rd_i) |=> !reg_ack_o) else $error("stray ack");
	a_rdata_idle: assert property (
		!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("stray rdata");
	a_sleep_idle: assert property (
		!control_input_three_i && !control_input_six_i
		|=> sleep_request_o == '0) else $error("sleep without input");
	a_sleep_full: assert property (
		config_ready_o && control_input_three_i && control_input_six_i
		|=> &sleep_request_o) else $error("sleep not raised");
	a_ready_holds: assert property (
		config_ready_o |=> config_ready_o) else $error("ready dropped");
	a_four_push_pull: assert property (
		config_ready_o ##1 config_ready_o |-> out_pin_oe_o[OUTPUTS-1])
		else $error("output four not driven");
	a_od_never_high: assert property (
		(out_pin_o & ~out_pin_oe_o) == '0) else $error("undriven high");
endmodule : cfg_slice_chk
bind sleep_gpo_addr_config_regs cfg_slice_chk
	#(.RAILS(RAILS), .OUTPUTS(OUTPUTS)) chk_i
(
	.clk_i                 (clk_i),
	.nrst_i                (nrst_i),
	.reg_wr_i              (reg_wr_i),
	.reg_rd_i              (reg_rd_i),
	.reg_rdata_o           (reg_rdata_o),
	.reg_ack_o             (reg_ack_o),
	.control_input_three_i (control_input_three_i),
	.control_input_six_i   (control_input_six_i),
	.sleep_request_o       (sleep_request_o),
	.out_pin_o             (out_pin_o),
	.out_pin_oe_o          (out_pin_oe_o),
	.config_ready_o        (config_ready_o)
);

// >>> dv/reg_host.sv
// register host model driving the slice's register port
`timescale 1ns/1ps
module reg_host
(
	input  wire logic       clk_i,
	input  wire logic       reg_ack_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o
);
	initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
	// released address and data lines show the inverse, not the old value
	task automatic xfer(input logic wr, input logic [7:0] a, d,
		output logic ack, output logic [7:0] q);
		@(negedge clk_i);
		{reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {wr, !wr, a, d};
		@(negedge clk_i);
		ack = reg_ack_i;
		q = reg_rdata_i;
		{reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
	endtask : xfer
endmodule : reg_host

// >>> dv/sleep_gpo_addr_config_regs_tb_top.sv
// self-checking bench for the configuration slice
`timescale 1ns/1ps
module sleep_gpo_addr_config_regs_tb_top;
	logic        clk_i, nrst_i, otp_valid_i, reg_wr_i, reg_rd_i, reg_ack_o;
	logic        control_input_three_i, control_input_six_i, config_ready_o;
	logic [7:0]  otp_sleep_source_i, otp_out_config_i, otp_target_addr_i;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, sleep_request_o;
	logic [7:0]  q, s, o, t, pins;
	logic [6:0]  target_address_o, a;
	logic [3:0]  power_good_i, sw_out_value_i, out_pin_o, out_pin_oe_o;
	logic        ack;
	logic [31:0] seed = 32'h0001_43DE;
	int          n_fail = 0;
	int          compares = 0;
	sleep_gpo_addr_config_regs sleep_gpo_addr_config_regs_i
	(
		.clk_i                 (clk_i),
		.nrst_i                (nrst_i),
		.otp_valid_i           (otp_valid_i),
		.otp_sleep_source_i    (otp_sleep_source_i),
		.otp_out_config_i      (otp_out_config_i),
		.otp_target_addr_i     (otp_target_addr_i),
		.reg_wr_i              (reg_wr_i),
		.reg_rd_i              (reg_rd_i),
		.reg_addr_i            (reg_addr_i),
		.reg_wdata_i           (reg_wdata_i),
		.reg_rdata_o           (reg_rdata_o),
		.reg_ack_o             (reg_ack_o),
		.target_address_o      (target_address_o),
		.control_input_three_i (control_input_three_i),
		.control_input_six_i   (control_input_six_i),
		.sleep_request_o       (sleep_request_o),
		.power_good_i          (power_good_i),
		.sw_out_value_i        (sw_out_value_i),
		.out_pin_o             (out_pin_o),
		.out_pin_oe_o          (out_pin_oe_o),
		.config_ready_o        (config_ready_o)
	);
	reg_host reg_host_i (.clk_i(clk_i), .reg_ack_i(reg_ack_o),
		.reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	function automatic logic [7:0] exp_pins(input logic [7:0] c, t);
		logic [3:0] src;
		src = (c[7:4] & t[7:4]) | (~c[7:4] & t[3:0]);
		return {1'b1, ~c[2:0] | ~src[2:0], src[3], src[2:0] & ~c[2:0]};
	endfunction : exp_pins
	task automatic check(input logic [15:0] seen, exp, input string m);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : check
	task automatic final_report();
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic rw(input logic w, input logic [7:0] ad, d);
		reg_host_i.xfer(w, ad, d, ack, q);
		check({ack, w ? 8'h00 : q}, {1'b1, w ? 8'h00 : d}, "reg");
	endtask : rw
	initial
	begin
		clk_i = 0;
		forever #25 clk_i = ~clk_i;
	end
	initial
	begin
		{nrst_i, otp_valid_i, control_input_three_i, control_input_six_i} = '0;
		{power_good_i, sw_out_value_i} = rnd();
		otp_sleep_source_i = rnd();
		otp_out_config_i = rnd();
		otp_target_addr_i = rnd();
		repeat (2) @(negedge clk_i);
		nrst_i = 1'b1;
		// image not yet valid: a write is dropped and nothing is live
		{control_input_three_i, control_input_six_i} = 2'b11;
		reg_host_i.xfer(1'b1, 8'h29, 8'hFF, ack, q);
		check({ack, sleep_request_o, config_ready_o}, '0, "early");
		check(target_address_o, 7'h5E, "early addr");
		otp_valid_i = 1'b1;
		for (int i = 0; i < 20 && config_ready_o !== 1'b1; i++)
			@(negedge clk_i);
		check(config_ready_o, 1'b1, "load timeout");
		t = {sw_out_value_i, power_good_i};
		a = otp_target_addr_i[7] ? otp_target_addr_i[6:0] : 7'h5E;
		o = otp_out_config_i;
		pins = {out_pin_oe_o, out_pin_o};
		check(target_address_o, a, "otp addr");
		check(pins, exp_pins(o, t), "otp pins");
		rw(0, 8'h29, otp_sleep_source_i);
		rw(0, 8'h2A, otp_out_config_i);
		rw(0, 8'h2B, otp_target_addr_i);
		rw(0, 8'h30, 8'h00);
		rw(1, 8'h30, 8'hA5);
		for (int k = 0; k < 16; k++)
		begin
			s = rnd();
			o = rnd();
			t = rnd();
			{control_input_three_i, control_input_six_i} = k[1:0];
			{sw_out_value_i, power_good_i} = t;
			if (k[3])
				a = 7'h37 - 7'(t[4:0]);
			else
				a = 7'h39 + 7'(t % 8'd63);
			rw(1, 8'h29, s);
			rw(1, 8'h2A, o);
			rw(1, 8'h2B, {k[2], a});
			rw(0, 8'h29, s);
			rw(0, 8'h2A, o);
			rw(0, 8'h2B, {k[2], a});
			@(negedge clk_i);
			s = (~s & {8{k[1]}}) | (s & {8{k[0]}});
			a = k[2] ? a : 7'h5E;
			pins = {out_pin_oe_o, out_pin_o};
			check(sleep_request_o, s, "sleep");
			check(pins, exp_pins(o, t), "pins");
			check(target_address_o, a, "addr");
		end
		final_report();
	end
endmodule : sleep_gpo_addr_config_regs_tb_top
